// File: bench/flash_array_model.sv
/*
 flash array stand-in on the memory side of flash_security.
 assumes read data is wanted in the same cycle as the read strobe.
*/
`timescale 1ns/100ps
module flash_array_model (
  input wire logic clk,
  input wire logic [15:0] arr_addr,
  input wire logic arr_read,
  output logic [7:0] arr_rdata
);
  logic [7:0] junk_r = 8'h00;
  // idle data churns so a stale value never passes for a read
  always_ff @(posedge clk) junk_r <= junk_r + 8'h35;
  assign arr_rdata = arr_read ? (arr_addr[7:0] ^ 8'h3c) : junk_r;
endmodule

// File: bench/flash_security_properties.sv
/*
 port checker for flash_security, bound to every instance.
 assumes the single clock domain and synchronous reset of the block.
*/
`timescale 1ns/100ps
module flash_security_chk
  import flash_sec_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic [7:0] nonvolatile_option_byte,
  input wire logic background_mode_pin,
  input wire logic [15:0] mem_addr,
  input wire logic mem_read,
  input wire logic mem_write,
  input wire logic mem_vector_fetch,
  input wire logic mem_from_debug,
  input wire logic [7:0] mem_rdata,
  input wire logic [15:0] arr_addr,
  input wire logic arr_read,
  input wire logic arr_write,
  input wire logic secure,
  input wire logic debug_module_enable,
  input wire logic active_background,
  input wire logic program_erase_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence dbg_flash_read;
    secure && mem_from_debug && mem_read && mem_addr >= 16'h8000;
  endsequence
  sequence div_write_done;
    write && !waitrequest && address == OFF_CLK_DIV;
  endsequence
  AST_ONE_WAIT: assert property ($rose(read || write)
    |-> waitrequest ##1 !waitrequest) else $error("wait state count");
  AST_RESET_VEC: assert property (mem_read && mem_vector_fetch
    && mem_addr == 16'hfffe |-> arr_addr == 16'hfffe)
    else $error("reset vector moved");
  AST_DBG_BLOCK: assert property (secure && mem_from_debug
    && (mem_read || mem_write) && mem_addr >= 16'h8000
    |-> !arr_read && !arr_write) else $error("debug access passed");
  AST_DBG_ZERO: assert property (dbg_flash_read
    |=> mem_rdata == 8'h00) else $error("debug read not zero");
  AST_DBG_OFF: assert property (debug_module_enable == !secure)
    else $error("debug enable while secure");
  AST_BG_PIN: assert property ($fell(reset)
    |-> active_background == !background_mode_pin)
    else $error("background mode capture");
  AST_OPT_CODE: assert property (disable iff (1'b0) reset |=>
    secure == ($past(nonvolatile_option_byte[1:0]) != SEC_OPEN))
    else $error("security code decode");
  AST_PE_RESET: assert property (disable iff (1'b0) reset
    |=> !program_erase_enable) else $error("loaded flag after reset");
  AST_PE_STICKY: assert property (program_erase_enable
    |=> program_erase_enable) else $error("loaded flag dropped");
  AST_PE_SET: assert property (div_write_done
    |=> program_erase_enable) else $error("loaded flag not set");
  AST_PE_CAUSE: assert property ($rose(program_erase_enable)
    |-> $past(write && !waitrequest && address == OFF_CLK_DIV))
    else $error("loaded flag without write");
endmodule

bind flash_security flash_security_chk chk_u (.clk(clk), .reset(reset),
  .address(address), .read(read), .write(write),
  .waitrequest(waitrequest), .mem_addr(mem_addr),
  .nonvolatile_option_byte(nonvolatile_option_byte),
  .background_mode_pin(background_mode_pin), .mem_read(mem_read),
  .mem_write(mem_write), .mem_vector_fetch(mem_vector_fetch),
  .mem_from_debug(mem_from_debug), .mem_rdata(mem_rdata),
  .arr_addr(arr_addr), .arr_read(arr_read), .arr_write(arr_write),
  .secure(secure), .debug_module_enable(debug_module_enable),
  .active_background(active_background),
  .program_erase_enable(program_erase_enable));

// File: bench/flash_security_test.sv
/*
 self-checking bench for flash_security.
 assumes the array model answers reads with address low byte xor 3c.
*/
`timescale 1ns/100ps
module flash_security_test;
  import flash_sec_pkg::*;
  logic clk = 0, reset = 1, read = 0, write = 0, reg_from_debug = 0;
  logic [4:0] address = '0;
  logic [31:0] writedata = '0, readdata, rdv;
  logic waitrequest, background_mode_pin = 1, blank_check_pass = 0;
  logic [7:0] nonvolatile_option_byte = 8'h02;
  logic [7:0] nonvolatile_protect_byte = 8'h80;
  logic [63:0] backdoor_key_bytes = 64'h0123_4567_89ab_cdef;
  logic [15:0] mem_addr = '0, arr_addr, a_seen;
  logic mem_read = 0, mem_write = 0, mem_vector_fetch = 0;
  logic mem_from_debug = 0, mem_from_secure = 0, mem_from_ram = 0;
  logic [7:0] mem_wdata = '0, mem_rdata, arr_wdata, arr_rdata, d_seen;
  logic [7:0] wd_seen;
  logic arr_read, arr_write, rd_seen, wr_seen, secure, debug_module_enable;
  logic active_background, program_erase_enable, flash_timing_clock;
  int num_errors = 0, check_count = 0;
  flash_security dut_u (.clk(clk), .reset(reset), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest),
    .reg_from_debug(reg_from_debug), .mem_addr(mem_addr),
    .nonvolatile_option_byte(nonvolatile_option_byte),
    .nonvolatile_protect_byte(nonvolatile_protect_byte),
    .backdoor_key_bytes(backdoor_key_bytes),
    .background_mode_pin(background_mode_pin),
    .blank_check_pass(blank_check_pass), .mem_read(mem_read),
    .mem_write(mem_write), .mem_wdata(mem_wdata),
    .mem_vector_fetch(mem_vector_fetch), .mem_from_debug(mem_from_debug),
    .mem_from_secure(mem_from_secure), .mem_from_ram(mem_from_ram),
    .mem_rdata(mem_rdata), .arr_addr(arr_addr), .arr_read(arr_read),
    .arr_write(arr_write), .arr_wdata(arr_wdata), .arr_rdata(arr_rdata),
    .secure(secure), .debug_module_enable(debug_module_enable),
    .active_background(active_background),
    .program_erase_enable(program_erase_enable),
    .flash_timing_clock(flash_timing_clock));
  flash_array_model arr_u (.clk(clk), .arr_addr(arr_addr),
    .arr_read(arr_read), .arr_rdata(arr_rdata));
  always #2 clk = ~clk;
  task automatic chk(input logic [31:0] got, exp, input string m);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s %h not %h", $time, m, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [7:0] d);
    int n;
    @(posedge clk);
    write <= wr;
    read <= !wr;
    address <= a;
    writedata <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest);
    rdv = readdata;
    chk(n, 2, "bus wait states");
    write <= 0;
    read <= 0;
  endtask
  task automatic mem(input logic [15:0] a, input logic rd, wr, vec,
                     input logic [2:0] src, input logic [7:0] d);
    @(posedge clk);
    mem_addr <= a;
    mem_read <= rd;
    mem_write <= wr;
    mem_vector_fetch <= vec;
    mem_wdata <= d;
    {mem_from_debug, mem_from_secure, mem_from_ram} <= src;
    @(negedge clk);
    a_seen = arr_addr;
    rd_seen = arr_read;
    wr_seen = arr_write;
    wd_seen = arr_wdata;
    @(posedge clk);
    mem_read <= 0;
    mem_write <= 0;
    mem_vector_fetch <= 0;
    @(negedge clk);
    d_seen = mem_rdata;
  endtask
  task automatic do_reset(input logic [7:0] opt);
    @(posedge clk);
    reset <= 1;
    nonvolatile_option_byte <= opt;
    background_mode_pin <= ~background_mode_pin;
    repeat (12) @(posedge clk);
    reset <= 0;
  endtask
  task automatic t_codes;
    for (int c = 0; c < 4; c++) begin
      do_reset(8'h80 | 8'(c));
      bus(0, OFF_STATUS, 0);
      chk(rdv[ST_SECURE], c != 2, "secure bit");
      bus(0, OFF_OPTION, 0);
      chk(rdv, 32'h80 | c, "option copy");
    end
  endtask
  task automatic flash_timing_clock_gap(input int exp);
    int n;
    n = 0;
    while (!flash_timing_clock && n < 100) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!flash_timing_clock && n < 100);
    chk(n, exp, "flash clock period");
  endtask
  task automatic t_divider;
    do_reset(8'h82);
    mem(16'h9000, 0, 1, 0, 3'b010, 8'h11);
    bus(0, OFF_STATUS, 0);
    chk(rdv[ST_ACCERR], 1, "early flash write");
    chk(program_erase_enable, 0, "erase before load");
    // fast bench clock: divisor kept short, not in the flash clock window
    bus(1, OFF_CLK_DIV, 8'h43);
    bus(1, OFF_CLK_DIV, 8'h05);
    bus(0, OFF_CLK_DIV, 0);
    chk(rdv, 32'hc3, "divider value");
    chk(program_erase_enable, 1, "erase after load");
    flash_timing_clock_gap(32);
    bus(1, OFF_STATUS, 8'h08);
    bus(0, OFF_STATUS, 0);
    chk(rdv[ST_ACCERR], 0, "error flag clear");
    do_reset(8'h82);
    bus(1, OFF_CLK_DIV, 8'h03);
    flash_timing_clock_gap(4);
  endtask
  task automatic vec(input logic [7:0] p, input logic [15:0] a, exp);
    bus(1, OFF_PROTECT, p);
    mem(a, 1, 0, 1, 3'b010, 0);
    chk(a_seen, exp, "vector address");
    chk(d_seen, exp[7:0] ^ 8'h3c, "vector data");
  endtask
  task automatic t_redirect;
    do_reset(8'h82);
    bus(0, OFF_STATUS, 0);
    chk(rdv[ST_REDIR], 1, "redirect status");
    bus(1, OFF_PROTECT, 8'h40);
    bus(0, OFF_PROTECT, 0);
    chk(rdv, 32'h80, "app protect write");
    reg_from_debug <= 1;
    // a 32k region covers the whole flash, so nothing moves
    for (int f = 0; f < 8; f++)
      vec(8'h80 | 8'(f << 3), 16'hfffa,
          f > 5 ? 16'hfffa : 16'(16'hfffa - (16'h0200 << f)));
    vec(8'h80, 16'hfffe, 16'hfffe);
    vec(8'hc0, 16'hfffa, 16'hfffa);
    vec(8'h00, 16'hfffa, 16'hfffa);
    do_reset(8'hc2);
    vec(8'h80, 16'hfffa, 16'hfffa);
    reg_from_debug <= 0;
  endtask
  task automatic t_security;
    do_reset(8'h83);
    mem(16'h9000, 1, 0, 0, 3'b100, 0);
    chk({rd_seen, d_seen}, 0, "debug flash read");
    mem(16'h9001, 1, 0, 0, 3'b000, 0);
    chk({rd_seen, d_seen}, 0, "unsecured read");
    mem(16'h0100, 0, 1, 0, 3'b100, 8'h77);
    chk(wr_seen, 0, "debug ram write");
    mem(16'h9003, 0, 1, 0, 3'b010, 8'h5a);
    chk({wr_seen, wd_seen}, 9'h15a, "secure flash write");
    mem(16'h9002, 1, 0, 0, 3'b010, 0);
    chk({rd_seen, d_seen}, 9'h13e, "secure read");
  endtask
  task automatic key_try(input logic [7:0] opt, input logic [2:0] src,
                         input logic [7:0] x, input logic unl);
    int n;
    do_reset(opt);
    bus(1, OFF_CONFIG, 8'h20);
    mem(16'h9000, 1, 0, 0, 3'b010, 0);
    chk(d_seen, 0, "read in key entry");
    for (int i = 0; i < 8; i++) begin
      mem(16'(KEY_LO + i), 0, 1, 0, src,
          backdoor_key_bytes[63 - 8 * i -: 8] ^ x);
      chk(wr_seen, 0, "key write to array");
    end
    bus(1, OFF_CONFIG, 8'h00);
    n = 0;
    while (secure && n < 30) begin
      @(negedge clk);
      n++;
    end
    chk(secure, !unl, "key result");
    bus(0, OFF_STATUS, 0);
    chk(rdv[ST_KEYOK], unl, "key unlock status");
  endtask
  task automatic t_blank;
    do_reset(8'h83);
    blank_check_pass <= 1;
    @(posedge clk);
    blank_check_pass <= 0;
    @(negedge clk);
    chk(secure, 0, "blank check unlock");
  endtask
  task automatic give_verdict;
    if (num_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    do_reset(8'h82);
    t_codes();
    t_divider();
    t_redirect();
    t_security();
    key_try(8'h83, 3'b011, 8'h00, 1);
    key_try(8'h83, 3'b011, 8'h01, 0);
    key_try(8'h03, 3'b011, 8'h00, 0);
    key_try(8'h83, 3'b100, 8'h00, 0);
    t_blank();
    give_verdict();
  end
  initial begin
    #100000;
    num_errors++;
    give_verdict();
  end
endmodule

// File: rtl/flash_sec_pkg.sv
/*
 package of constants for the flash security and vector redirect block.
 assumes byte addressed avalon register offsets and a 16-bit cpu space.
*/
package flash_sec_pkg;
  // register byte offsets
  localparam logic [4:0] OFF_CLK_DIV = 5'h00;
  localparam logic [4:0] OFF_CONFIG = 5'h04;
  localparam logic [4:0] OFF_OPTION = 5'h08;
  localparam logic [4:0] OFF_PROTECT = 5'h0c;
  localparam logic [4:0] OFF_STATUS = 5'h10;
  // clock divider fields
  localparam int DIVIDER_LOADED_FLAG_BIT = 7;
  localparam int PRESCALE_BIT = 6;
  localparam logic [6:0] CLK_DIV_RST = 7'h00;
  localparam logic [2:0] PRESCALE_LAST = 3'h7;
  // config, option and protect fields
  localparam int KEY_ACCESS_ENABLE_BIT = 5;
  localparam int BACKDOOR_ENABLE_BIT = 7;
  localparam int NORED_BIT = 6;
  localparam int OPEN_BIT = 7;
  localparam int PDIS_BIT = 6;
  localparam int FPS_LSB = 3;
  localparam logic [1:0] SEC_OPEN = 2'h2;
  localparam logic [7:0] OPTION_MASK = 8'hc3;
  localparam logic [7:0] PROTECT_MASK = 8'hf8;
  // status bits
  localparam int ST_REDIR = 0;
  localparam int ST_SECURE = 1;
  localparam int ST_DIVIDER_LOADED_FLAG = 2;
  localparam int ST_ACCERR = 3;
  localparam int ST_KEYOK = 4;
  // cpu address map
  localparam logic [15:0] VEC_LO = 16'hffc0;
  localparam logic [15:0] VEC_HI = 16'hfffd;
  localparam logic [15:0] KEY_LO = 16'hffb0;
  localparam logic [15:0] KEY_HI = 16'hffb7;
  localparam logic [15:0] PROT_MIN = 16'h0200;
  localparam logic [15:0] PROT_MAX = 16'h8000;
  localparam logic [15:0] NONVOLATILE_PROTECT_BYTE_ADDR = 16'hffbd;
  localparam int KEY_BYTES = 8;
  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_ENTRY = 2'b01,
    KEY_CHECK = 2'b11,
    KEY_LAST = 2'b10
  } key_state_t;
endpackage

// File: rtl/flash_security.sv
/*
 flash security, vector redirect and flash clock divider.
 assumes memory requests arrive with source flags and array read data
 in the same cycle; registers sit on an avalon-mm slave.
*/
//
// Function
// R1: redirect only when flash partly protected
// R2: redirect ffc0-fffd, never the reset vector
// R3: vectors fetched just below protected region
// R4: secure blocks unsecured and debug memory access
// R5: code in secure memory keeps full access
// R6: only code 1:0 means unsecured
// R7: option byte copied into working register at reset
// R8: debug off when secure, background via pin
// R9: no key attempt without backdoor enable
// R10: key writes captured while key access set
// R11: software writes key ascending, not back-to-back
// R12: matching key unlocks until next reset
// R13: key writes accepted only from ram code
// R14: flash reads invalid while key access set
// R15: protect register written only by debug
// R16: passing blank check unlocks until reset
// R17: divider top bit status, low bits write-once
// R18: loaded flag gates program and erase
// R19: prescale select divides bus clock by eight
// R20: flash clock is input over divisor plus one
// R21: software keeps flash clock 150-200 khz
// R22: timing pulse lasts one flash clock; code drives flash_timing_clock high for one bus clock only
// R23: no redirect if flash closed or disabled
// R24: flash write before divider sets access error
// R25: secure derived combinationally from security code
`timescale 1ns/100ps
module flash_security
  import flash_sec_pkg::*;
#(
  parameter logic [15:0] FLASH_LO = 16'h8000,
  parameter logic [15:0] RAM_LO = 16'h0080,
  parameter logic [15:0] RAM_HI = 16'h087f
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic reg_from_debug,
  input wire logic [7:0] nonvolatile_option_byte,
  input wire logic [7:0] nonvolatile_protect_byte,
  input wire logic [63:0] backdoor_key_bytes,
  input wire logic background_mode_pin,
  input wire logic blank_check_pass,
  input wire logic [15:0] mem_addr,
  input wire logic mem_read,
  input wire logic mem_write,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_vector_fetch,
  input wire logic mem_from_debug,
  input wire logic mem_from_secure,
  input wire logic mem_from_ram,
  output logic [7:0] mem_rdata,
  output logic [15:0] arr_addr,
  output logic arr_read,
  output logic arr_write,
  output logic [7:0] arr_wdata,
  input wire logic [7:0] arr_rdata,
  output logic secure,
  output logic debug_module_enable,
  output logic active_background,
  output logic program_erase_enable,
  output logic flash_timing_clock
);
  // returns base of the protected top region for a size select
  function automatic logic [15:0] prot_base(input logic [2:0] fps);
    logic [15:0] size;
    size = PROT_MIN << fps;
    if (size > PROT_MAX || size == 16'h0000) begin
      size = PROT_MAX;
    end
    prot_base = 16'(16'h0000 - size);
  endfunction

  function automatic logic in_range(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  logic [7:0] working_option_reg, working_option_nxt;
  logic [7:0] working_protect_reg, working_protect_nxt;
  logic key_access_enable_r, key_access_enable_nxt;
  logic [6:0] div_r, div_nxt;
  logic divider_loaded_flag_r, divider_loaded_flag_nxt;
  logic access_error_flag_r, access_error_flag_nxt;
  logic key_ok_r, key_ok_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] readdata_r, readdata_nxt;
  logic bg_r, bg_nxt;
  logic [2:0] pre_cnt_r, pre_cnt_nxt;
  logic [5:0] div_cnt_r, div_cnt_nxt;
  logic flash_timing_clock_r, flash_timing_clock_nxt;
  logic [7:0] mem_rdata_r, mem_rdata_nxt;
  key_state_t key_st_r, key_st_nxt;
  logic [3:0] key_cnt_r, key_cnt_nxt;
  logic [2:0] chk_idx_r, chk_idx_nxt;
  logic key_bad_r, key_bad_nxt;

  logic req, wr_acc, rd_acc;
  logic redirect_on, is_flash, is_ram, blocked;
  logic is_key_loc, key_wr, pre_tick;
  logic [15:0] base;
  logic [7:0] key_rd_data;
  logic [7:0] key_ref;
  logic [2:0] ref_idx;
  logic key_cap_en;

  // security and redirect decode
  assign secure = working_option_reg[1:0] != SEC_OPEN; // R6 R25
  assign debug_module_enable = !secure; // R8
  assign active_background = bg_r; // R8
  assign program_erase_enable = divider_loaded_flag_r; // R18
  assign flash_timing_clock = flash_timing_clock_r;
  assign base = prot_base(working_protect_reg[FPS_LSB+:3]);
  // open flash with a block protected means partial protection
  assign redirect_on = working_protect_reg[OPEN_BIT] && // R1 R23
                       !working_protect_reg[PDIS_BIT] && // R1
                       base > FLASH_LO && // R1
                       !working_option_reg[NORED_BIT]; // R23

  assign is_flash = mem_addr >= FLASH_LO;
  assign is_ram = in_range(mem_addr, RAM_LO, RAM_HI);
  // register space is unsecured, only flash and ram are gated
  assign blocked = secure && (is_flash || is_ram) && // R4
                   (mem_from_debug || !mem_from_secure); // R4 R5
  assign is_key_loc = in_range(mem_addr, KEY_LO, KEY_HI);
  // debug cannot supply the key alone: ram code only
  assign key_wr = mem_write && is_key_loc && key_access_enable_r; // R10
  assign key_cap_en = key_wr && mem_from_ram && !mem_from_debug && // R13
                      working_option_reg[BACKDOOR_ENABLE_BIT] && // R9
                      key_cnt_r < 4'(KEY_BYTES) && !blocked;

  // array side request
  always_comb begin
    arr_addr = mem_addr;
    arr_wdata = mem_wdata;
    arr_read = mem_read && !blocked;
    arr_write = mem_write && !blocked && !key_wr; // R10
    if (mem_read && mem_vector_fetch && redirect_on &&
        in_range(mem_addr, VEC_LO, VEC_HI)) begin // R2
      // vectors sit in the 64 bytes just under the region
      arr_addr = {10'(base[15:6] - 10'h001), mem_addr[5:0]}; // R3
    end
  end

  // read data are zero when blocked, or for flash reads while key access is open
  always_comb begin
    mem_rdata_nxt = arr_rdata;
    if (blocked) begin
      mem_rdata_nxt = 8'h00; // R4
    end else if (key_access_enable_r && is_flash) begin
      mem_rdata_nxt = 8'h00; // R14
    end
  end
  assign mem_rdata = mem_rdata_r;

  // avalon slave: one wait state, answer on second edge
  assign req = read || write;
  assign waitrequest = req && !ack_r;
  assign wr_acc = write && ack_r;
  assign rd_acc = read && !ack_r;
  assign readdata = readdata_r;

  always_comb begin
    ack_nxt = req && !ack_r;
    readdata_nxt = readdata_r;
    if (rd_acc) begin
      readdata_nxt = 32'h0000_0000;
      if (address == OFF_CLK_DIV) begin
        readdata_nxt[7:0] = {divider_loaded_flag_r, div_r}; // R17
      end else if (address == OFF_CONFIG) begin
        readdata_nxt[KEY_ACCESS_ENABLE_BIT] = key_access_enable_r;
      end else if (address == OFF_OPTION) begin
        readdata_nxt[7:0] = working_option_reg & OPTION_MASK;
      end else if (address == OFF_PROTECT) begin
        readdata_nxt[7:0] = working_protect_reg & PROTECT_MASK;
      end else if (address == OFF_STATUS) begin
        readdata_nxt[ST_REDIR] = redirect_on;
        readdata_nxt[ST_SECURE] = secure;
        readdata_nxt[ST_DIVIDER_LOADED_FLAG] = divider_loaded_flag_r;
        readdata_nxt[ST_ACCERR] = access_error_flag_r;
        readdata_nxt[ST_KEYOK] = key_ok_r;
      end
    end
  end

  // control registers
  always_comb begin
    working_option_nxt = working_option_reg;
    working_protect_nxt = working_protect_reg;
    key_access_enable_nxt = key_access_enable_r;
    div_nxt = div_r;
    divider_loaded_flag_nxt = divider_loaded_flag_r;
    access_error_flag_nxt = access_error_flag_r;
    key_ok_nxt = key_ok_r;
    if (wr_acc && address == OFF_CLK_DIV && !divider_loaded_flag_r) begin
      div_nxt = writedata[6:0]; // R17
      divider_loaded_flag_nxt = 1'b1; // R18
    end
    if (wr_acc && address == OFF_CONFIG) begin
      key_access_enable_nxt = writedata[KEY_ACCESS_ENABLE_BIT];
    end
    // application writes to protection are dropped
    if (wr_acc && address == OFF_PROTECT && reg_from_debug) begin
      working_protect_nxt = writedata[7:0] & PROTECT_MASK; // R15
    end
    if (wr_acc && address == OFF_STATUS && writedata[ST_ACCERR]) begin
      access_error_flag_nxt = 1'b0;
    end
    // set after clear so a same-cycle error survives
    if (mem_write && is_flash && !blocked && !key_wr &&
        !divider_loaded_flag_r) begin
      access_error_flag_nxt = 1'b1; // R24
    end
    if (blank_check_pass) begin
      working_option_nxt[1:0] = SEC_OPEN; // R16
    end
    if (key_st_r == KEY_LAST && !key_bad_r) begin
      working_option_nxt[1:0] = SEC_OPEN; // R12
      key_ok_nxt = 1'b1;
    end
  end

  // key entry and comparison sequencer
  always_comb begin
    key_st_nxt = key_st_r;
    key_cnt_nxt = key_cnt_r;
    chk_idx_nxt = chk_idx_r;
    key_bad_nxt = key_bad_r;
    case (key_st_r)
      KEY_IDLE: begin
        key_cnt_nxt = 4'h0;
        if (key_access_enable_r && working_option_reg[BACKDOOR_ENABLE_BIT]) begin
          key_st_nxt = KEY_ENTRY; // R9
        end
      end
      KEY_ENTRY: begin
        // bytes land in ascending order from the first location
        if (key_cap_en) begin
          key_cnt_nxt = 4'(key_cnt_r + 4'h1); // R11
        end
        if (!key_access_enable_r) begin
          chk_idx_nxt = 3'h0;
          key_cnt_nxt = 4'h0;
          key_bad_nxt = key_cnt_r != 4'(KEY_BYTES);
          key_st_nxt = KEY_CHECK; // R12
        end
      end
      KEY_CHECK: begin
        // buffer output lags the index by one cycle
        if (key_cnt_r != 4'h0) begin
          key_bad_nxt = key_bad_r || (key_rd_data != key_ref);
        end
        key_cnt_nxt = 4'h1;
        chk_idx_nxt = 3'(chk_idx_r + 3'h1);
        if (key_cnt_r != 4'h0 && chk_idx_r == 3'h0) begin
          key_st_nxt = KEY_LAST;
        end
      end
      KEY_LAST: begin
        key_st_nxt = KEY_IDLE;
      end
      default: begin
        key_st_nxt = KEY_IDLE;
      end
    endcase
  end

  // first stored byte sits in the top lane of the key input
  assign ref_idx = 3'(chk_idx_r - 3'h1);
  assign key_ref = backdoor_key_bytes[8'(63 - 8 * ref_idx) -: 8];

  key_buf #(
    .W(8),
    .D(KEY_BYTES),
    .AW(3)
  ) u_key_buf (
    .clk(clk),
    .wr_en(key_cap_en), // R10
    .wr_addr(mem_addr[2:0]),
    .wr_data(mem_wdata),
    .rd_addr(chk_idx_r),
    .rd_data_r(key_rd_data)
  );

  // flash timing clock divider, one-cycle enable pulses
  assign pre_tick = !div_r[PRESCALE_BIT] || // R19
                    pre_cnt_r == PRESCALE_LAST; // R19
  always_comb begin
    pre_cnt_nxt = 3'(pre_cnt_r + 3'h1);
    div_cnt_nxt = div_cnt_r;
    flash_timing_clock_nxt = 1'b0;
    if (!divider_loaded_flag_r) begin
      pre_cnt_nxt = 3'h0;
      div_cnt_nxt = 6'h00;
    end else if (pre_tick) begin
      if (div_cnt_r == div_r[5:0]) begin
        div_cnt_nxt = 6'h00;
        flash_timing_clock_nxt = 1'b1; // R20 R22
      end else begin
        div_cnt_nxt = 6'(div_cnt_r + 6'h01); // R20
      end
    end
  end

  // background entry caught from the pin while reset is held
  always_comb begin
    bg_nxt = bg_r;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      working_option_reg <= nonvolatile_option_byte; // R7
      working_protect_reg <= nonvolatile_protect_byte & PROTECT_MASK;
      bg_r <= !background_mode_pin; // R8
      key_access_enable_r <= 1'b0;
      div_r <= CLK_DIV_RST;
      divider_loaded_flag_r <= 1'b0; // R18
      access_error_flag_r <= 1'b0;
      key_ok_r <= 1'b0;
      ack_r <= 1'b0;
      readdata_r <= 32'h0000_0000;
      pre_cnt_r <= 3'h0;
      div_cnt_r <= 6'h00;
      flash_timing_clock_r <= 1'b0;
      mem_rdata_r <= 8'h00;
      key_st_r <= KEY_IDLE;
      key_cnt_r <= 4'h0;
      chk_idx_r <= 3'h0;
      key_bad_r <= 1'b0;
    end else begin
      working_option_reg <= working_option_nxt;
      working_protect_reg <= working_protect_nxt;
      bg_r <= bg_nxt;
      key_access_enable_r <= key_access_enable_nxt;
      div_r <= div_nxt;
      divider_loaded_flag_r <= divider_loaded_flag_nxt;
      access_error_flag_r <= access_error_flag_nxt;
      key_ok_r <= key_ok_nxt;
      ack_r <= ack_nxt;
      readdata_r <= readdata_nxt;
      pre_cnt_r <= pre_cnt_nxt;
      div_cnt_r <= div_cnt_nxt;
      flash_timing_clock_r <= flash_timing_clock_nxt;
      mem_rdata_r <= mem_rdata_nxt;
      key_st_r <= key_st_nxt;
      key_cnt_r <= key_cnt_nxt;
      chk_idx_r <= chk_idx_nxt;
      key_bad_r <= key_bad_nxt;
    end
  end
endmodule

// File: rtl/key_buf.sv
/*
 small byte store for the entered backdoor comparison key.
 assumes one write port and one read port, read data one cycle late.
*/
`timescale 1ns/100ps
module key_buf #(
  parameter int W = 8,
  parameter int D = 8,
  parameter int AW = 3
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data_r
);
  logic [W-1:0] mem_r [D];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
    rd_data_r <= mem_r[rd_addr];
  end
endmodule
